/* File: hdl/gcfg_pkg.sv */
// Constants and types shared by the global configuration and timer block
package gcfg_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_COUNT_LOW  = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_TIMER_CMD  = 8'h08;
  localparam logic [7:0] OFS_EIGHT_SEL  = 8'h0c;
  localparam logic [7:0] OFS_FOUR_SEL   = 8'h10;
  localparam logic [7:0] OFS_SOFT_RST   = 8'h14;
  localparam logic [7:0] OFS_SLEEP_EN   = 8'h18;
  localparam logic [7:0] OFS_DEVICE_ID  = 8'h1c;
  localparam logic [7:0] OFS_REVISION   = 8'h20;
  localparam logic [7:0] OFS_BROADCAST  = 8'h24;
  // Field positions
  localparam int CMD_LSB     = 0;
  localparam int CMD_MSB     = 3;
  localparam int PEND_BIT    = 0;
  localparam int BCAST_BIT   = 0;
  // Timer command codes
  localparam logic [3:0] CMD_IRQ_ON   = 4'h1;
  localparam logic [3:0] CMD_IRQ_OFF  = 4'h2;
  localparam logic [3:0] CMD_ONE_SHOT = 4'h3;
  localparam logic [3:0] CMD_PERIODIC = 4'h4;
  localparam logic [3:0] CMD_SRC_XTAL = 4'h5;
  localparam logic [3:0] CMD_SRC_EXT  = 4'h6;
  localparam logic [3:0] CMD_START    = 4'h9;
  localparam logic [3:0] CMD_STOP     = 4'ha;
  localparam logic [3:0] CMD_RESET    = 4'hb;
  // Reset values
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  // Crystal clocks from wake-up to full function
  localparam int unsigned WAKE_CLOCKS = 32;
  // Interrupt source code reported on channel 0 for a timer time-out
  localparam logic [2:0] TIMER_SRC_CODE = 3'h7;
  localparam logic [2:0] NO_SRC_CODE    = 3'h0;

  typedef enum logic [2:0] {
    PWR_AWAKE  = 3'b001,
    PWR_ASLEEP = 3'b010,
    PWR_WARMUP = 3'b100
  } power_state_t;
endpackage

/* File: hdl/octal_uart_global_config_timer.sv */
// Device configuration registers, 16-bit timer, sampling, reset and sleep control
`timescale 1ns/10ps
module octal_uart_global_config_timer
  import gcfg_pkg::*;
#(
  parameter int         NCH         = 8,
  parameter int         CW          = 16,
  parameter logic [7:0] DEVICE_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] REV_CODE    = 8'h0a  // Arbitrary value
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  input  wire logic           external_timer_clock_in,
  input  wire logic [NCH-1:0] chan_irq_pending,
  input  wire logic [NCH-1:0] chan_wake_event,
  input  wire logic           chan_cfg_write,
  input  wire logic [2:0]     chan_cfg_select,
  output logic [NCH-1:0]      chan_cfg_write_en,
  output logic [NCH-1:0]      chan_eight_x,
  output logic [NCH-1:0]      chan_four_x,
  output logic [NCH-1:0]      chan_soft_reset,
  output logic [NCH-1:0]      chan_asleep,
  output logic                osc_enable,
  output logic                device_ready,
  output logic                wake_irq,
  output logic                timer_irq,
  output logic [2:0]          chan0_src_code
);
  typedef struct packed {
    logic [CW-1:0]  count;
    logic           irq_en;
    logic           one_shot;
    logic           ext_src;
    logic           pending;
    logic [NCH-1:0] eight;
    logic [NCH-1:0] four;
    logic [NCH-1:0] soft_rst;
    logic [NCH-1:0] sleep_en;
    logic           bcast;
    logic           wake_irq;
    power_state_t   pwr;
    logic [5:0]     warm;
    logic [NCH-1:0] asleep;
    logic           ext_prev;
    logic           wr_pend;
    logic [7:0]     wr_addr;
    logic [31:0]    rdata;
  } state_t;

  state_t         s_reg;
  state_t         s_next;
  logic           acc;
  logic [7:0]     acc_addr;
  logic           cmd_wr;
  logic [3:0]     cmd_code;
  logic           t_start;
  logic           t_stop;
  logic           t_clear;
  logic           t_tick;
  logic           t_timeout;
  logic           t_running;
  logic [NCH-1:0] pend_all;
  logic [NCH-1:0] may_sleep;

  assign acc      = hsel & hready & htrans[1];
  assign acc_addr = {haddr[7:2], 2'b00};
  assign cmd_wr   = s_reg.wr_pend & (s_reg.wr_addr == OFS_TIMER_CMD);
  assign cmd_code = hwdata[CMD_MSB:CMD_LSB];
  assign t_start  = cmd_wr & (cmd_code == CMD_START);
  assign t_stop   = cmd_wr & (cmd_code == CMD_STOP);
  assign t_clear  = cmd_wr & (cmd_code == CMD_RESET);
  // Pin is synchronous to hclk, so one flop is enough for the edge
  assign t_tick   = s_reg.ext_src ? (external_timer_clock_in & ~s_reg.ext_prev)
                                  : 1'b1;

  timer_countdown #(
    .CW (CW)
  ) u_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick     (t_tick),
    .start    (t_start),
    .stop     (t_stop),
    .clear    (t_clear),
    .one_shot (s_reg.one_shot),
    .reload   (s_reg.count),
    .timeout  (t_timeout),
    .running  (t_running)
  );

  // Channel 0 also counts the timer and wake flags as pending work
  assign pend_all = chan_irq_pending | {{(NCH-1){1'b0}}, s_reg.pending | s_reg.wake_irq};

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      assign may_sleep[gi]         = s_reg.sleep_en[gi] & ~pend_all[gi];
      assign chan_eight_x[gi]      = s_reg.eight[gi];
      assign chan_four_x[gi]       = s_reg.four[gi] & ~s_reg.eight[gi];
      assign chan_cfg_write_en[gi] = chan_cfg_write &
                                     (s_reg.bcast | (chan_cfg_select == 3'(gi)));
    end
  endgenerate

  always_comb begin
    s_next          = s_reg;
    s_next.wr_pend  = 1'b0;
    s_next.soft_rst = '0;
    s_next.ext_prev = external_timer_clock_in;
    // Data phase of a write
    if (s_reg.wr_pend) begin
      case (s_reg.wr_addr)
        OFS_COUNT_LOW:  s_next.count[7:0]  = hwdata[7:0];
        OFS_COUNT_HIGH: s_next.count[15:8] = hwdata[7:0];
        OFS_EIGHT_SEL:  s_next.eight       = hwdata[NCH-1:0];
        OFS_FOUR_SEL:   s_next.four        = hwdata[NCH-1:0];
        OFS_SOFT_RST:   s_next.soft_rst    = hwdata[NCH-1:0];
        OFS_SLEEP_EN:   s_next.sleep_en    = hwdata[NCH-1:0];
        OFS_BROADCAST:  s_next.bcast       = hwdata[BCAST_BIT];
        OFS_TIMER_CMD: begin
          case (cmd_code)
            CMD_IRQ_ON:   s_next.irq_en   = 1'b1;
            CMD_IRQ_OFF:  s_next.irq_en   = 1'b0;
            CMD_ONE_SHOT: s_next.one_shot = 1'b1;
            CMD_PERIODIC: s_next.one_shot = 1'b0;
            CMD_SRC_XTAL: s_next.ext_src  = 1'b0;
            CMD_SRC_EXT:  s_next.ext_src  = 1'b1;
            default:      s_next.irq_en   = s_reg.irq_en;
          endcase
        end
        default: s_next.bcast = s_reg.bcast;
      endcase
    end
    // Address phase; reads see a write finishing in the same cycle, except soft reset, which reads the registered pulse
    if (acc && hwrite) begin
      s_next.wr_pend = 1'b1;
      s_next.wr_addr = acc_addr;
    end
    if (acc && !hwrite) begin
      case (acc_addr)
        OFS_COUNT_LOW:  s_next.rdata = {24'h0, s_next.count[7:0]};
        OFS_COUNT_HIGH: s_next.rdata = {24'h0, s_next.count[15:8]};
        OFS_TIMER_CMD:  s_next.rdata = {31'h0, s_reg.pending};
        OFS_EIGHT_SEL:  s_next.rdata = {24'h0, s_next.eight};
        OFS_FOUR_SEL:   s_next.rdata = {24'h0, s_next.four};
        OFS_SOFT_RST:   s_next.rdata = {24'h0, s_reg.soft_rst};
        OFS_SLEEP_EN:   s_next.rdata = {24'h0, s_next.sleep_en};
        OFS_DEVICE_ID:  s_next.rdata = {24'h0, DEVICE_CODE};
        OFS_REVISION:   s_next.rdata = {24'h0, REV_CODE};
        OFS_BROADCAST:  s_next.rdata = {31'h0, s_next.bcast};
        default:        s_next.rdata = 32'h0;
      endcase
      if (acc_addr == OFS_TIMER_CMD) begin
        s_next.pending = 1'b0;
      end
      if (acc_addr == OFS_SLEEP_EN) begin
        s_next.wake_irq = 1'b0;
      end
    end
    // A time-out in the clearing cycle is kept: set wins
    if (t_timeout && s_reg.irq_en) begin
      s_next.pending = 1'b1;
    end
    // Sleep and wake sequencing
    s_next.asleep = '0;
    case (s_reg.pwr)
      PWR_AWAKE: begin
        s_next.asleep = may_sleep;
        if (&may_sleep) begin
          s_next.pwr = PWR_ASLEEP;
        end
      end
      PWR_ASLEEP: begin
        s_next.asleep = may_sleep;
        if (|chan_wake_event) begin
          s_next.pwr    = PWR_WARMUP;
          s_next.warm   = '0;
          s_next.asleep = '0;
        end else if (!(&may_sleep)) begin
          s_next.pwr = PWR_AWAKE;
        end
      end
      PWR_WARMUP: begin
        s_next.warm = s_reg.warm + 6'd1;
        if (s_reg.warm == 6'(WAKE_CLOCKS - 1)) begin
          s_next.pwr      = PWR_AWAKE;
          s_next.wake_irq = 1'b1;
        end
      end
      default: s_next.pwr = PWR_AWAKE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg          <= '0;
      s_reg.count    <= RST_COUNT;
      s_reg.eight    <= RST_BYTE;
      s_reg.four     <= RST_BYTE;
      s_reg.sleep_en <= RST_BYTE;
      s_reg.pwr      <= PWR_AWAKE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = s_reg.rdata;
  assign chan_soft_reset = s_reg.soft_rst;
  assign chan_asleep     = s_reg.asleep;
  // Clocks keep running here; the real oscillator gate sits outside
  assign osc_enable      = (s_reg.pwr != PWR_ASLEEP);
  assign device_ready    = (s_reg.pwr != PWR_WARMUP);
  assign wake_irq        = s_reg.wake_irq;
  assign timer_irq       = s_reg.pending;
  // Wake-up reports code zero: no source pending
  assign chan0_src_code  = s_reg.pending ? TIMER_SRC_CODE : NO_SRC_CODE;

  property p_cmd_read;
    @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && acc_addr == OFS_TIMER_CMD) |=>
        hrdata == {31'h0, $past(s_reg.pending)};
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command read value wrong");

  property p_cmd_no_echo;
    @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && acc_addr == OFS_TIMER_CMD) |=> hrdata[31:1] == 31'h0;
  endproperty
  a_cmd_no_echo: assert property (p_cmd_no_echo) else $error("command code echoed");

  property p_irq_on;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && cmd_code == CMD_IRQ_ON) |=> s_reg.irq_en;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq enable failed");

  property p_irq_off;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && cmd_code == CMD_IRQ_OFF) |=> !s_reg.irq_en;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq disable failed");

  property p_mode;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && cmd_code == CMD_ONE_SHOT) |=> s_reg.one_shot;
  endproperty
  a_mode: assert property (p_mode) else $error("one-shot not selected");

  property p_src;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && cmd_code == CMD_SRC_EXT) |=> s_reg.ext_src;
  endproperty
  a_src: assert property (p_src) else $error("external source not selected");

  property p_start;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && cmd_code == CMD_START) |=> t_running;
  endproperty
  a_start: assert property (p_start) else $error("timer did not start");

  property p_reserved;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && (cmd_code == 4'h7 || cmd_code == 4'h8 || cmd_code >= 4'hc)) |=>
        $stable({s_reg.irq_en, s_reg.one_shot, s_reg.ext_src, t_running});
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");

  property p_one_shot_stops;
    @(posedge hclk) disable iff (!hresetn)
      (t_timeout && s_reg.one_shot && !t_start) |=> !t_running;
  endproperty
  a_one_shot_stops: assert property (p_one_shot_stops) else $error("one-shot kept running");

  property p_read_clears;
    @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && acc_addr == OFS_TIMER_CMD && !t_timeout) |=> !s_reg.pending;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_both_eight;
    @(posedge hclk) disable iff (!hresetn)
      (|(s_reg.eight & s_reg.four)) |-> !(|(chan_four_x & s_reg.eight));
  endproperty
  a_both_eight: assert property (p_both_eight) else $error("4X over 8X");

  property p_soft_rst;
    @(posedge hclk) disable iff (!hresetn)
      (|s_reg.soft_rst && !(s_reg.wr_pend && s_reg.wr_addr == OFS_SOFT_RST)) |=>
        s_reg.soft_rst == '0;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset stuck");

  property p_warmup;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_reg.pwr == PWR_WARMUP) |-> !device_ready ##32 device_ready && wake_irq;
  endproperty
  a_warmup: assert property (p_warmup) else $error("wake-up timing wrong");

  property p_osc_off;
    @(posedge hclk) disable iff (!hresetn)
      !osc_enable |-> $past(&may_sleep);
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator stopped early");

  property p_code7;
    @(posedge hclk) disable iff (!hresetn)
      (t_timeout && s_reg.irq_en) |=> chan0_src_code == 3'h7;
  endproperty
  a_code7: assert property (p_code7) else $error("timer code missing");
endmodule // octal_uart_global_config_timer

/* File: hdl/timer_countdown.sv */
// Down counter that produces the general purpose timer time-out
`timescale 1ns/10ps
module timer_countdown
  import gcfg_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          tick,
  input  wire logic          start,
  input  wire logic          stop,
  input  wire logic          clear,
  input  wire logic          one_shot,
  input  wire logic [CW-1:0] reload,
  output logic               timeout,
  output logic               running
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          run;
  } tstate_t;

  tstate_t s_reg;
  tstate_t s_next;

  always_comb begin
    s_next  = s_reg;
    // Time-out is combinational so the flag lands exactly N ticks after start
    timeout = s_reg.run & tick & (s_reg.cnt == CW'(1));
    if (s_reg.run && tick) begin
      if (s_reg.cnt == CW'(1)) begin
        s_next.cnt = reload;
        if (one_shot) begin
          s_next.run = 1'b0;
        end
      end else begin
        s_next.cnt = s_reg.cnt - CW'(1);
      end
    end
    if (stop) begin
      s_next.run = 1'b0;
    end
    if (clear) begin
      s_next.run = 1'b0;
      s_next.cnt = reload;
    end
    if (start) begin
      s_next.run = 1'b1;
      s_next.cnt = reload;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign running = s_reg.run;
endmodule // timer_countdown

/* File: test/ahb_host_model.sv */
// Bus host model issuing single word transfers to the configuration block
`timescale 1ns/10ps
module ahb_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Called just after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Released data lines must not keep showing the last value
    hwdata <= ~wd;
  endtask
endmodule // ahb_host_model

/* File: test/octal_uart_global_config_timer_tb_top.sv */
// Self-checking bench for the configuration and timer block
`timescale 1ns/10ps
module octal_uart_global_config_timer_tb_top;
  import gcfg_pkg::*;
  localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
  localparam logic [7:0] REV = 8'h0a; // Arbitrary value
  localparam int N = 5;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_clk, cfg_wr, osc_enable;
  logic device_ready, wake_irq, timer_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cfg_sel, src;
  logic [7:0]  pend, wake, wr_en, e8, f4, srst, asleep;
  int fail_count, comparisons, cyc, n;

  ahb_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  octal_uart_global_config_timer #(.DEVICE_CODE(DEV), .REV_CODE(REV)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_timer_clock_in(ext_clk), .chan_irq_pending(pend), .chan_wake_event(wake),
    .chan_cfg_write(cfg_wr), .chan_cfg_select(cfg_sel), .chan_cfg_write_en(wr_en),
    .chan_eight_x(e8), .chan_four_x(f4), .chan_soft_reset(srst), .chan_asleep(asleep),
    .osc_enable(osc_enable), .device_ready(device_ready), .wake_irq(wake_irq),
    .timer_irq(timer_irq), .chan0_src_code(src));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, ofs, d, r);
  endtask

  task automatic rdchk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] r;
    host.xfer(1'b0, ofs, 32'h0, r);
    check(name, r, exp);
    #1;
  endtask

  task automatic edges(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  task automatic t_reset_values;
    rdchk("cmd", OFS_TIMER_CMD, 32'h0);
    rdchk("eight", OFS_EIGHT_SEL, 32'h0);
    rdchk("four", OFS_FOUR_SEL, 32'h0);
    rdchk("srst", OFS_SOFT_RST, 32'h0);
    rdchk("sleep", OFS_SLEEP_EN, 32'h0);
    rdchk("bcast", OFS_BROADCAST, 32'h0);
    rdchk("unmapped", 8'h3c, 32'h0);
    wr(OFS_DEVICE_ID, 32'hff);
    wr(OFS_REVISION, 32'hff);
    rdchk("devid", OFS_DEVICE_ID, {24'h0, DEV});
    rdchk("rev", OFS_REVISION, {24'h0, REV});
    check("osc", osc_enable, 1'b1);
    check("hresp", hresp, 1'b0);
  endtask

  task automatic t_one_shot;
    wr(OFS_COUNT_LOW, 32'(N));
    wr(OFS_COUNT_HIGH, 32'h0);
    // Interrupt enabled first so a reserved code that started the timer would show
    wr(OFS_TIMER_CMD, CMD_IRQ_ON);
    for (int c = 7; c < 16; c++) begin
      if (c != 9 && c != 10 && c != 11) wr(OFS_TIMER_CMD, c);
    end
    edges(2 * N);
    check("irq reserved", timer_irq, 1'b0);
    wr(OFS_TIMER_CMD, CMD_ONE_SHOT);
    wr(OFS_TIMER_CMD, CMD_START);
    edges(N - 1);
    check("irq early", timer_irq, 1'b0);
    edges(1);
    check("irq", timer_irq, 1'b1);
    check("src", src, TIMER_SRC_CODE);
    rdchk("cmd pend", OFS_TIMER_CMD, 32'h1);
    check("irq cleared", timer_irq, 1'b0);
    rdchk("cmd idle", OFS_TIMER_CMD, 32'h0);
    edges(2 * N);
    check("irq once", timer_irq, 1'b0);
  endtask

  task automatic t_periodic;
    wr(OFS_TIMER_CMD, CMD_PERIODIC);
    wr(OFS_TIMER_CMD, CMD_START);
    edges(N);
    check("irq p1", timer_irq, 1'b1);
    rdchk("cmd p1", OFS_TIMER_CMD, 32'h1);
    edges(N - 3);
    check("irq gap", timer_irq, 1'b0);
    edges(1);
    check("irq p2", timer_irq, 1'b1);
    wr(OFS_TIMER_CMD, CMD_STOP);
    rdchk("cmd p2", OFS_TIMER_CMD, 32'h1);
    edges(2 * N);
    check("irq stopped", timer_irq, 1'b0);
    wr(OFS_TIMER_CMD, CMD_START);
    edges(2);
    wr(OFS_TIMER_CMD, CMD_RESET);
    edges(2 * N);
    check("irq reset", timer_irq, 1'b0);
    wr(OFS_TIMER_CMD, CMD_IRQ_OFF);
    wr(OFS_TIMER_CMD, CMD_START);
    edges(2 * N);
    check("irq masked", timer_irq, 1'b0);
    wr(OFS_TIMER_CMD, CMD_STOP);
  endtask

  task automatic t_ext_clock;
    wr(OFS_TIMER_CMD, CMD_SRC_EXT);
    wr(OFS_TIMER_CMD, CMD_ONE_SHOT);
    wr(OFS_TIMER_CMD, CMD_IRQ_ON);
    wr(OFS_TIMER_CMD, CMD_START);
    edges(3 * N);
    check("ext idle", timer_irq, 1'b0);
    for (int i = 0; i < N; i++) begin
      if (i == N - 1) check("ext early", timer_irq, 1'b0);
      ext_clk <= 1'b1;
      edges(1);
      ext_clk <= 1'b0;
      edges(1);
    end
    n = 0;
    while (timer_irq !== 1'b1 && n < 4) begin
      edges(1);
      n++;
    end
    check("ext irq", timer_irq, 1'b1);
    rdchk("cmd ext", OFS_TIMER_CMD, 32'h1);
    wr(OFS_TIMER_CMD, CMD_SRC_XTAL);
    wr(OFS_TIMER_CMD, CMD_START);
    edges(N);
    check("xtal irq", timer_irq, 1'b1);
    rdchk("cmd xtal", OFS_TIMER_CMD, 32'h1);
  endtask

  task automatic t_select_reset_bcast;
    wr(OFS_EIGHT_SEL, 32'h05);
    wr(OFS_FOUR_SEL, 32'h0c);
    #1;
    check("eight", e8, 8'h05);
    check("four", f4, 8'h08);
    rdchk("four rd", OFS_FOUR_SEL, 32'h0c);
    wr(OFS_SOFT_RST, 32'ha5);
    #1;
    check("srst pulse", srst, 8'ha5);
    edges(1);
    check("srst clear", srst, 8'h00);
    rdchk("srst rd", OFS_SOFT_RST, 32'h0);
    cfg_wr <= 1'b1;
    cfg_sel <= 3'h3;
    edges(1);
    check("single", wr_en, 8'h08);
    wr(OFS_BROADCAST, 32'h1);
    #1;
    check("broadcast", wr_en, 8'hff);
    cfg_wr <= 1'b0;
    edges(1);
    check("no write", wr_en, 8'h00);
  endtask

  task automatic t_sleep;
    wr(OFS_SLEEP_EN, 32'hff);
    edges(3);
    check("asleep pend", asleep, 8'hfe);
    check("osc on", osc_enable, 1'b1);
    pend <= 8'h00;
    edges(3);
    check("asleep all", asleep, 8'hff);
    check("osc off", osc_enable, 1'b0);
    wake <= 8'h10;
    edges(1);
    wake <= 8'h00;
    check("warming", device_ready, 1'b0);
    n = 0;
    do begin
      edges(1);
      n++;
    end while (device_ready !== 1'b1 && n < 100);
    check("warm cycles", n, 32);
    check("wake irq", wake_irq, 1'b1);
    check("wake src", src, NO_SRC_CODE);
    wr(OFS_SLEEP_EN, 32'h0);
    rdchk("sleep rd", OFS_SLEEP_EN, 32'h0);
    check("wake clr", wake_irq, 1'b0);
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    hresetn = 1'b0;
    ext_clk = 1'b0;
    pend = 8'h01;
    wake = 8'h00;
    cfg_wr = 1'b0;
    cfg_sel = 3'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_one_shot();
    t_periodic();
    t_ext_clock();
    t_select_reset_bcast();
    t_sleep();
    tally_and_finish();
  end
endmodule // octal_uart_global_config_timer_tb_top
